/* File: status_log.sv */
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - holds twenty records, capacity reads twenty
// - each record is four 16-bit words
// - power on code 1, power loss 2
// - run entry code 3, run exit 4
// - restore defaults writes code 5
// - clear key writes code 6
// - pointer advances, marks newest record
// - pointer spans 0 to 19
// - timestamp packed after action code
// - year month day stored as BCD
// - hour minute second stored as BCD
// - always high flag reads one from the first enabled edge after reset
// - always low flag reads zero
// - first scan pulse high one scan
// - inverted first scan low in the first scan and while stopped
module status_log
    import status_log_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] prdata,
    input  wire logic        ev_power_on,
    input  wire logic        ev_power_loss,
    input  wire logic        ev_run_start,
    input  wire logic        ev_run_stop,
    input  wire logic        ev_defaults,
    input  wire logic        ev_clear_key,
    input  wire logic        scan_end,
    input  wire logic [7:0]  cal_year,
    input  wire logic [7:0]  cal_month,
    input  wire logic [7:0]  cal_day,
    input  wire logic [7:0]  cal_hour,
    input  wire logic [7:0]  cal_minute,
    input  wire logic [7:0]  cal_second,
    output logic             always_high_flag,
    output logic             always_low_flag,
    output logic             first_scan_pulse_flag,
    output logic             inverted_first_scan_flag,
    output logic             clear_latched_pulse
);
    typedef enum logic [1:0] {SCAN_IDLE, SCAN_FIRST, SCAN_LATER} scan_state_t;

    // ************************************************************
    // record storage and pointer
    // ************************************************************
    logic [15:0] action_r  [LOG_DEPTH];
    logic [15:0] ym_r      [LOG_DEPTH];
    logic [15:0] dh_r      [LOG_DEPTH];
    logic [15:0] ms_r      [LOG_DEPTH];
    logic [4:0]  ptr_r;
    logic [4:0]  ptr_nxt;
    logic [15:0] log_count_r;
    logic        ev_any;
    logic [15:0] ev_code;
    logic        running_r;
    scan_state_t scan_r;

    // one event per cycle; lower codes win when several coincide
    always_comb begin
        ev_any  = 1'b1;
        ev_code = ACT_POWER_ON;
        if (ev_power_on) begin
            ev_code = ACT_POWER_ON;
        end else if (ev_power_loss) begin
            ev_code = ACT_POWER_OFF;
        end else if (ev_run_start) begin
            ev_code = ACT_RUN;
        end else if (ev_run_stop) begin
            ev_code = ACT_STOP;
        end else if (ev_defaults) begin
            ev_code = ACT_DEFAULTS;
        end else if (ev_clear_key) begin
            ev_code = ACT_CLEAR;
        end else begin
            ev_any  = 1'b0;
        end
    end

    // advance, wrapping after the last slot
    always_comb begin
        if (ptr_r == PTR_LAST) begin
            ptr_nxt = 5'h00;
        end else begin
            ptr_nxt = ptr_r + 5'h01;
        end
    end

    // reset value points at the last slot so the first event lands in slot 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r       <= PTR_RESET;
            log_count_r <= 16'h0000;
        end else if (clk_en && ev_any) begin
            ptr_r <= ptr_nxt;
            if (log_count_r != LOG_CAPACITY) begin
                log_count_r <= log_count_r + 16'h0001;
            end
        end
    end

    // one slot per record, written with the calendar at detection time
    genvar g;
    generate
        for (g = 0; g < LOG_DEPTH; g++) begin : g_slot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    action_r[g] <= 16'h0000;
                    ym_r[g]     <= 16'h0000;
                    dh_r[g]     <= 16'h0000;
                    ms_r[g]     <= 16'h0000;
                end else if (clk_en && ev_any && ptr_nxt == 5'(g)) begin
                    action_r[g] <= ev_code;
                    ym_r[g]     <= {cal_year, cal_month};
                    dh_r[g]     <= {cal_day, cal_hour};
                    ms_r[g]     <= {cal_minute, cal_second};
                end
            end
        end
    endgenerate

    // ************************************************************
    // operation flags
    // ************************************************************
    // scan tracker: first scan runs from run entry to the first scan_end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_r    <= SCAN_IDLE;
            running_r <= 1'b0;
        end else if (clk_en) begin
            if (ev_run_stop || ev_power_loss) begin
                running_r <= 1'b0;
            end else if (ev_run_start) begin
                running_r <= 1'b1;
            end
            case (scan_r)
                SCAN_IDLE: begin
                    if (ev_run_start && !ev_run_stop && !ev_power_loss) begin
                        scan_r <= SCAN_FIRST;
                    end
                end
                SCAN_FIRST: begin
                    if (ev_run_stop || ev_power_loss) begin
                        scan_r <= SCAN_IDLE;
                    end else if (scan_end) begin
                        scan_r <= SCAN_LATER;
                    end
                end
                SCAN_LATER: begin
                    if (ev_run_stop || ev_power_loss) begin
                        scan_r <= SCAN_IDLE;
                    end
                end
                default: begin
                    scan_r <= SCAN_IDLE;
                end
            endcase
        end
    end

    // flags registered from the tracker; first scan pulse spans one scan
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            always_high_flag         <= 1'b0;
            always_low_flag          <= 1'b0;
            first_scan_pulse_flag    <= 1'b0;
            inverted_first_scan_flag <= 1'b0;
            clear_latched_pulse      <= 1'b0;
        end else if (clk_en) begin
            always_high_flag         <= 1'b1;
            always_low_flag          <= 1'b0;
            first_scan_pulse_flag    <= (scan_r == SCAN_FIRST);
            inverted_first_scan_flag <= (scan_r == SCAN_LATER);
            clear_latched_pulse      <= ev_clear_key;
        end
    end

    // ************************************************************
    // apb slave, read only; one wait state
    // ************************************************************
    logic [9:0]  widx;
    logic [9:0]  roff;
    logic [4:0]  rslot;
    logic [31:0] rdata_nxt;
    logic        rerr_nxt;

    assign widx  = paddr[11:2];
    assign roff  = widx - IDX_AREA_FIRST;
    assign rslot = roff[6:2];

    // decode; writes are refused, unmapped words answer with an error
    always_comb begin
        rdata_nxt = DATA_RESET;
        rerr_nxt  = 1'b0;
        if (pwrite) begin
            rerr_nxt = 1'b1;
        end else if (widx == IDX_CAPACITY) begin
            rdata_nxt = {16'h0000, LOG_CAPACITY};
        end else if (widx == IDX_POINTER) begin
            rdata_nxt = {27'h000_0000, ptr_r};
        end else if (widx >= IDX_AREA_FIRST && widx <= IDX_AREA_LAST) begin
            case (roff[1:0])
                2'b00:   rdata_nxt = {16'h0000, action_r[rslot]};
                2'b01:   rdata_nxt = {16'h0000, ym_r[rslot]};
                2'b10:   rdata_nxt = {16'h0000, dh_r[rslot]};
                default: rdata_nxt = {16'h0000, ms_r[rslot]};
            endcase
        end else if (widx == IDX_FLAGS) begin
            rdata_nxt[FLAG_HIGH_BIT]  = always_high_flag;
            rdata_nxt[FLAG_LOW_BIT]   = always_low_flag;
            rdata_nxt[FLAG_FIRST_BIT] = first_scan_pulse_flag;
            rdata_nxt[FLAG_INV_BIT]   = inverted_first_scan_flag;
            rdata_nxt[FLAG_RUN_BIT]   = running_r;
        end else if (widx == IDX_LOG_COUNT) begin
            rdata_nxt = {16'h0000, log_count_r};
        end else begin
            rerr_nxt = 1'b1;
        end
    end

    // pready pulses in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= DATA_RESET;
        end else if (clk_en) begin
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                pslverr <= rerr_nxt;
                prdata  <= rdata_nxt;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // the pointer stays inside the twenty slots and names the newest record
    ptr_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        ptr_r <= PTR_LAST)
        else $error("pointer out of range");
    ptr_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_any && ptr_r == PTR_LAST) |=> ptr_r == 5'h00)
        else $error("pointer did not wrap");
    ptr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_any && ptr_r != PTR_LAST) |=> ptr_r == $past(ptr_r) + 5'h01)
        else $error("pointer did not advance");
    // a frozen enable or a quiet cycle must not move the pointer
    ptr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!clk_en || !ev_any) |=> $stable(ptr_r))
        else $error("pointer moved without event");
    // the fill count saturates at the capacity
    count_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        log_count_r <= LOG_CAPACITY)
        else $error("fill count above capacity");

    // ************************************************************
    // action codes
    // ************************************************************
    // priority is rebuilt from the event pins, except the clear check, which uses the encoder
    power_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_power_on) |=> action_r[ptr_r] == ACT_POWER_ON)
        else $error("power on code wrong");
    loss_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_power_loss && !ev_power_on) |=> action_r[ptr_r] == ACT_POWER_OFF)
        else $error("power loss code wrong");
    run_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_run_start && !ev_power_on && !ev_power_loss)
        |=> action_r[ptr_r] == ACT_RUN)
        else $error("run code wrong");
    stop_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_run_stop && !ev_power_on && !ev_power_loss && !ev_run_start)
        |=> action_r[ptr_r] == ACT_STOP)
        else $error("stop code wrong");
    defaults_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_defaults && !ev_power_on && !ev_power_loss && !ev_run_start
            && !ev_run_stop) |=> action_r[ptr_r] == ACT_DEFAULTS)
        else $error("defaults code wrong");
    clear_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_any && ev_code == ACT_CLEAR)
        |=> action_r[ptr_r] == ACT_CLEAR)
        else $error("clear code wrong");
    // the erase strobe follows the key even when a lower code wins the slot
    clear_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> clear_latched_pulse == $past(ev_clear_key))
        else $error("clear pulse wrong");

    // ************************************************************
    // timestamps
    // ************************************************************
    // the calendar is taken in the event cycle, not one later
    stamp_date_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_any) |=> ym_r[ptr_r] == {$past(cal_year), $past(cal_month)}
            && dh_r[ptr_r] == {$past(cal_day), $past(cal_hour)})
        else $error("date not captured");
    stamp_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_any) |=> ms_r[ptr_r] == {$past(cal_minute), $past(cal_second)})
        else $error("timestamp not captured");

    // ************************************************************
    // operation flags and fill count
    // ************************************************************
    // constants settle one enabled edge after reset, so skip that edge
    const_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(presetn) && $past(clk_en)) |-> always_high_flag && !always_low_flag)
        else $error("constant flags wrong");
    count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ev_any && log_count_r != LOG_CAPACITY)
        |=> log_count_r == $past(log_count_r) + 16'h0001)
        else $error("fill count did not step");
    first_scan_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(first_scan_pulse_flag && inverted_first_scan_flag))
        else $error("scan flags overlap");
    scan_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && scan_r == SCAN_IDLE && ev_run_start && !ev_run_stop && !ev_power_loss)
        ##1 clk_en |=> first_scan_pulse_flag)
        else $error("first scan missing");
    // one scan later the pulse ends and the inverted flag rises
    scan_later_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && scan_r == SCAN_FIRST && scan_end && !ev_run_stop && !ev_power_loss)
        ##1 clk_en |=> inverted_first_scan_flag && !first_scan_pulse_flag)
        else $error("first scan did not end");
    scan_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && (ev_run_stop || ev_power_loss)) ##1 clk_en
        |=> !first_scan_pulse_flag && !inverted_first_scan_flag)
        else $error("scan flags not cleared");

    // ************************************************************
    // register bus
    // ************************************************************
    // every access made while clk_en is high is answered after exactly one wait state
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && psel && penable && !pready) |=> pready)
        else $error("apb answer late");
    // the answer stands one cycle so a slow master is not answered twice
    apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && pready) |=> !pready)
        else $error("apb answer held");
    write_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && psel && penable && !pready && pwrite) |=> pready && pslverr)
        else $error("write not refused");
    // a frozen enable holds the scan state, pready and the fill count
    freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(scan_r) && $stable(pready) && $stable(log_count_r))
        else $error("state moved while frozen");

    // ************************************************************
    // scenarios worth seeing
    // ************************************************************
    power_on_c: cover property (@(posedge pclk) disable iff (!presetn)
        clk_en && ev_power_on);
    wrap_c: cover property (@(posedge pclk) disable iff (!presetn)
        clk_en && ev_any && ptr_r == PTR_LAST);
    first_scan_c: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(first_scan_pulse_flag) && inverted_first_scan_flag);
    clear_shared_c: cover property (@(posedge pclk) disable iff (!presetn)
        clk_en && ev_clear_key && ev_power_on);
    apb_error_c: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);
endmodule
`default_nettype wire

/* File: status_log_pkg.sv */
`default_nettype none
package status_log_pkg;
    // ************************************************************
    // geometry of the log
    // ************************************************************
    localparam int          LOG_DEPTH      = 20;
    localparam int          REGS_PER_ENTRY = 4;
    localparam logic [15:0] LOG_CAPACITY   = 16'h0014;
    localparam logic [4:0]  PTR_LAST       = 5'h13;
    localparam logic [4:0]  PTR_RESET      = 5'h13;

    // ************************************************************
    // action codes
    // ************************************************************
    localparam logic [15:0] ACT_POWER_ON   = 16'h0001;
    localparam logic [15:0] ACT_POWER_OFF  = 16'h0002;
    localparam logic [15:0] ACT_RUN        = 16'h0003;
    localparam logic [15:0] ACT_STOP       = 16'h0004;
    localparam logic [15:0] ACT_DEFAULTS   = 16'h0005;
    localparam logic [15:0] ACT_CLEAR      = 16'h0006;

    // ************************************************************
    // register word indexes, byte address is four times the index
    // ************************************************************
    localparam logic [9:0]  IDX_CAPACITY   = 10'h135;
    localparam logic [9:0]  IDX_POINTER    = 10'h136;
    localparam logic [9:0]  IDX_AREA_FIRST = 10'h137;
    localparam logic [9:0]  IDX_AREA_LAST  = 10'h186;
    localparam logic [9:0]  IDX_FLAGS      = 10'h190;
    localparam logic [9:0]  IDX_LOG_COUNT  = 10'h191;

    // ************************************************************
    // flag register bit positions
    // ************************************************************
    localparam int          FLAG_HIGH_BIT  = 0;
    localparam int          FLAG_LOW_BIT   = 1;
    localparam int          FLAG_FIRST_BIT = 2;
    localparam int          FLAG_INV_BIT   = 3;
    localparam int          FLAG_RUN_BIT   = 4;

    localparam logic [31:0] DATA_RESET     = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: status_log_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module status_log_tb_top
    import status_log_pkg::*;
;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        clk_en  = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [5:0]  ev_v    = 6'h00;
    logic        scan_end = 1'b0;
    logic [47:0] cal_v   = 48'h0000_0000_0000;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        ahf;
    logic        alf;
    logic        fsp;
    logic        ifs;
    logic        clp;
    int          fails = 0;
    int          samples_checked = 0;
    int          ptr_exp;
    logic [31:0] d;
    logic        e;

    status_log u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .ev_power_on(ev_v[0]), .ev_power_loss(ev_v[1]), .ev_run_start(ev_v[2]),
        .ev_run_stop(ev_v[3]), .ev_defaults(ev_v[4]), .ev_clear_key(ev_v[5]),
        .scan_end(scan_end), .cal_year(cal_v[47:40]), .cal_month(cal_v[39:32]),
        .cal_day(cal_v[31:24]), .cal_hour(cal_v[23:16]), .cal_minute(cal_v[15:8]),
        .cal_second(cal_v[7:0]), .always_high_flag(ahf), .always_low_flag(alf),
        .first_scan_pulse_flag(fsp), .inverted_first_scan_flag(ifs),
        .clear_latched_pulse(clp));

    // ************************************************************
    // clock, closing and compare helpers
    // ************************************************************
    always #4 pclk = ~pclk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // apb transfer: hold the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= 32'h0000_00a5;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) chk("pready wait", 32'h0000_0001, 32'h0000_0000);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] rv;
        logic        ev;
        apb(1'b0, idx, rv, ev);
        chk({what, " data"}, exp, rv);
        chk({what, " error"}, 32'h0000_0000, {31'h0, ev});
    endtask

    // one event pulse; calendar is scrambled right after so a late sample shows up
    task automatic fire(input logic [5:0] v, input logic [47:0] cal);
        logic [15:0] code;
        logic [9:0]  base;
        code = 16'h0000;
        for (int i = 5; i >= 0; i--) if (v[i]) code = 16'(i + 1);
        @(posedge pclk);
        ev_v  <= v;
        cal_v <= cal;
        @(posedge pclk);
        ev_v  <= 6'h00;
        cal_v <= ~cal;
        #1;
        chk("clear pulse", {31'h0, v[5]}, {31'h0, clp});
        ptr_exp = (ptr_exp + 1) % LOG_DEPTH;
        base = IDX_AREA_FIRST + 10'(REGS_PER_ENTRY * ptr_exp);
        rd_chk("pointer", IDX_POINTER, 32'(ptr_exp));
        rd_chk("action", base, {16'h0000, code});
        rd_chk("year month", base + 10'h001, {16'h0000, cal[47:32]});
        rd_chk("day hour", base + 10'h002, {16'h0000, cal[31:16]});
        rd_chk("minute second", base + 10'h003, {16'h0000, cal[15:0]});
    endtask

    task automatic flags_chk(input logic [31:0] reg_exp, input logic f, input logic inv);
        chk("first scan", {31'h0, f}, {31'h0, fsp});
        chk("inverted scan", {31'h0, inv}, {31'h0, ifs});
        rd_chk("flags", IDX_FLAGS, reg_exp);
    endtask

    task automatic scan_pulse;
        @(posedge pclk);
        scan_end <= 1'b1;
        @(posedge pclk);
        scan_end <= 1'b0;
        @(posedge pclk);
        #1;
    endtask

    // ************************************************************
    // watchdog at 50000 cycles, far above the few hundred cycles the tests take
    // ************************************************************
    initial begin
        #400000;
        chk("watchdog", 32'h0000_0000, 32'h0000_0001);
        end_sim();
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        ptr_exp = 19;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("capacity", IDX_CAPACITY, {16'h0000, LOG_CAPACITY});
        rd_chk("reset pointer", IDX_POINTER, 32'h0000_0013);
        rd_chk("reset count", IDX_LOG_COUNT, 32'h0000_0000);
        chk("high flag", 32'h0000_0001, {31'h0, ahf});
        chk("low flag", 32'h0000_0000, {31'h0, alf});
        flags_chk(32'h0000_0001, 1'b0, 1'b0);
        $display("test reset values done");

        fire(6'h01, 48'h9912_3123_5959);
        fire(6'h02, 48'h0001_0100_0000);
        fire(6'h04, 48'h2406_1512_3045);
        flags_chk(32'h0000_0015, 1'b1, 1'b0);
        scan_pulse();
        flags_chk(32'h0000_0019, 1'b0, 1'b1);
        scan_pulse();
        flags_chk(32'h0000_0019, 1'b0, 1'b1);
        fire(6'h08, 48'h2406_1512_3146);
        flags_chk(32'h0000_0001, 1'b0, 1'b0);
        fire(6'h10, 48'h2507_0908_0712);
        fire(6'h20, 48'h2507_0908_0713);
        $display("test action codes done");

        fire(6'h30, 48'h2508_2019_4401);
        fire(6'h21, 48'h2508_2019_4402);
        $display("test simultaneous events done");

        // frozen clock enable: an event pulse must leave the log untouched
        @(posedge pclk);
        clk_en <= 1'b0;
        ev_v   <= 6'h01;
        @(posedge pclk);
        ev_v   <= 6'h00;
        @(posedge pclk);
        clk_en <= 1'b1;
        rd_chk("frozen pointer", IDX_POINTER, 32'(ptr_exp));
        $display("test clock enable done");

        for (int i = 0; i < 13; i++) fire(6'(1 << (i % 2)), 48'h3011_2806_1522);
        rd_chk("wrapped pointer", IDX_POINTER, 32'h0000_0000);
        rd_chk("log count", IDX_LOG_COUNT, {16'h0000, LOG_CAPACITY});
        $display("test wrap done");

        apb(1'b1, IDX_CAPACITY, d, e);
        chk("write error", 32'h0000_0001, {31'h0, e});
        rd_chk("capacity kept", IDX_CAPACITY, {16'h0000, LOG_CAPACITY});
        apb(1'b0, 10'h18f, d, e);
        chk("unmapped error", 32'h0000_0001, {31'h0, e});
        chk("unmapped data", 32'h0000_0000, d);
        $display("test refused access done");
        end_sim();
    end
endmodule
`default_nettype wire
